// ---- rtl/coc_pkg.sv ----
package coc_pkg;
    // Byte addresses of the two halves on the serial management bus
    localparam logic [7:0] ADDR_LOW  = 8'h34;
    localparam logic [7:0] ADDR_HIGH = 8'h35;

    // Power-on value of the whole 16-bit register
    localparam logic [15:0] RESET_VALUE = 16'h0030;

    // Upper byte bit positions
    localparam int HI_HIGHZ     = 7;
    localparam int HI_SOFT_RST  = 6;
    localparam int HI_REMEASURE = 5;
    localparam int HI_BUS_SUP   = 4;
    localparam int HI_ICO       = 3;

    // Lower byte bit positions
    localparam int LO_CONS      = 6;
    localparam int LO_PIN_SEL   = 5;
    localparam int LO_CLAMP_HI  = 4;
    localparam int LO_CLAMP_LO  = 3;
    localparam int LO_LOW_RANGE = 2;
    localparam int LO_BATSW_OFF = 1;
    localparam int LO_PMON_SEL  = 0;

    // Value read back for an address this block does not own
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // Inductor average current clamp codes and their limits in amperes
    localparam logic [1:0] CLAMP_6A   = 2'h0;
    localparam logic [1:0] CLAMP_10A  = 2'h1;
    localparam logic [1:0] CLAMP_15A  = 2'h2;
    localparam logic [1:0] CLAMP_OFF  = 2'h3;
    localparam logic [4:0] AMPS_6     = 5'h06;
    localparam logic [4:0] AMPS_10    = 5'h0A;
    localparam logic [4:0] AMPS_15    = 5'h0F;
    localparam logic [4:0] AMPS_NONE  = 5'h00;

    // Single-cell minimum system voltage reloaded on soft reset, in mV
    localparam logic [11:0] MIN_SYS_1CELL_MV = 12'hE00;

    // Stored fields of the register
    typedef struct packed {
        logic       highz_mode_enable;
        logic       input_vreg_remeasure;
        logic       bus_supply_mode_enable;
        logic       input_current_optimizer_enable;
        logic       conservative_assist_enable;
        logic       shared_pin_function_select;
        logic [1:0] inductor_avg_current_clamp;
        logic       bus_supply_low_range;
        logic       battery_switch_off_in_highz;
        logic       power_monitor_bus_supply_select;
    } coc_fields_t;

    // Whole state of the control block
    typedef struct packed {
        coc_fields_t f;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        highz;
        logic        regulator_on;
        logic        sys_from_battery;
        logic        battery_switch_on;
        logic        converter_enable;
        logic        regs_reset;
        logic        remeasure_start;
        logic        bus_supply_active;
        logic        assist_pin_enable;
        logic        optimizer_run;
        logic        conservative_assist;
        logic        low_range;
        logic        pmon_subtract_bus;
        logic [4:0]  clamp_amps;
        logic        clamp_disabled;
    } coc_state_t;
endpackage : coc_pkg

// ---- rtl/coc_clamp_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module coc_clamp_decode (
    input  wire logic [1:0] i_code,      // Clamp field code
    output logic      [4:0] o_amps,      // Clamp limit in amperes
    output logic            o_disabled   // Clamp switched off
);
    // Map the two-bit code onto its current limit
    always_comb begin
        o_disabled = 1'b0;
        case (i_code)
            coc_pkg::CLAMP_6A:  o_amps = coc_pkg::AMPS_6;
            coc_pkg::CLAMP_10A: o_amps = coc_pkg::AMPS_10;
            coc_pkg::CLAMP_15A: o_amps = coc_pkg::AMPS_15;
            default: begin
                o_amps     = coc_pkg::AMPS_NONE;
                o_disabled = 1'b1;
            end
        endcase
    end
endmodule : coc_clamp_decode
`default_nettype wire

// ---- rtl/coc_option_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module coc_option_ctrl (
    input  wire logic       i_ref_clk,          // System clock, 100 MHz
    input  wire logic       i_rst,              // Synchronous reset, active high
    input  wire logic [7:0] i_reg_addr,         // Byte address from the serial bus engine
    input  wire logic       i_reg_wr,           // Byte write strobe
    input  wire logic       i_reg_rd,           // Byte read strobe
    input  wire logic [7:0] i_reg_wdata,        // Byte write data
    input  wire logic       i_vbus_above_uvlo,  // Input supply above lockout
    input  wire logic       i_shared_pin,       // Shared bus supply / assist pin
    input  wire logic       i_remeasure_done,   // Threshold measurement finished
    output logic      [7:0] o_reg_rdata,        // Byte read data
    output logic            o_reg_rvalid,       // Read data valid, one cycle
    output logic            o_highz,            // High-impedance mode active
    output logic            o_regulator_on,     // Internal regulator enable
    output logic            o_sys_from_battery, // System powered from battery
    output logic            o_battery_switch_on,// Battery switch closed
    output logic            o_converter_enable, // Converter allowed to switch
    output logic            o_regs_reset,       // Soft reset pulse to other registers
    output logic            o_remeasure_start,  // Start threshold measurement pulse
    output logic            o_bus_supply_active,// Supplying bus from battery
    output logic            o_assist_pin_enable,// Pin requests voltage-assist mode
    output logic            o_optimizer_run,    // Input current optimizer running
    output logic            o_conservative_assist, // Conservative assist variant
    output logic            o_low_range,        // Bus supply low voltage range
    output logic            o_pmon_subtract_bus,// Monitor subtracts bus output power
    output logic      [4:0] o_clamp_amps,       // Inductor clamp limit in amperes
    output logic            o_clamp_disabled,   // Inductor clamp off
    output logic     [11:0] o_min_sys_reload_mv // Minimum system value for soft reset
);

    coc_pkg::coc_state_t  st;
    coc_pkg::coc_state_t  next_st;
    coc_pkg::coc_fields_t def_f;
    coc_pkg::coc_fields_t nf;
    logic [4:0]           clamp_amps;
    logic                 clamp_off;
    logic                 wr_hi;
    logic                 wr_lo;
    logic                 soft_rst;

    // Power-on field values, unpacked from the documented register value
    always_comb begin
        def_f.highz_mode_enable               = coc_pkg::RESET_VALUE[8 + coc_pkg::HI_HIGHZ];
        def_f.input_vreg_remeasure            = coc_pkg::RESET_VALUE[8 + coc_pkg::HI_REMEASURE];
        def_f.bus_supply_mode_enable          = coc_pkg::RESET_VALUE[8 + coc_pkg::HI_BUS_SUP];
        def_f.input_current_optimizer_enable  = coc_pkg::RESET_VALUE[8 + coc_pkg::HI_ICO];
        def_f.conservative_assist_enable      = coc_pkg::RESET_VALUE[coc_pkg::LO_CONS];
        def_f.shared_pin_function_select      = coc_pkg::RESET_VALUE[coc_pkg::LO_PIN_SEL];
        def_f.inductor_avg_current_clamp      =
            coc_pkg::RESET_VALUE[coc_pkg::LO_CLAMP_HI:coc_pkg::LO_CLAMP_LO];
        def_f.bus_supply_low_range            = coc_pkg::RESET_VALUE[coc_pkg::LO_LOW_RANGE];
        def_f.battery_switch_off_in_highz     = coc_pkg::RESET_VALUE[coc_pkg::LO_BATSW_OFF];
        def_f.power_monitor_bus_supply_select = coc_pkg::RESET_VALUE[coc_pkg::LO_PMON_SEL];
    end

    // Byte decode of the two addresses
    assign wr_hi    = i_reg_wr && (i_reg_addr == coc_pkg::ADDR_HIGH);
    assign wr_lo    = i_reg_wr && (i_reg_addr == coc_pkg::ADDR_LOW);
    assign soft_rst = wr_hi && i_reg_wdata[coc_pkg::HI_SOFT_RST];

    // Clamp decode feeds the registered clamp outputs
    coc_clamp_decode u_clamp (
        .i_code     (nf.inductor_avg_current_clamp),
        .o_amps     (clamp_amps),
        .o_disabled (clamp_off)
    );

    // Next-state logic: field writes, self-clearing bits, derived controls
    always_comb begin
        next_st = st;
        nf      = st.f;
        // Byte writes; reserved bits are simply not stored
        if (wr_hi) begin
            nf.highz_mode_enable              = i_reg_wdata[coc_pkg::HI_HIGHZ];
            nf.bus_supply_mode_enable         = i_reg_wdata[coc_pkg::HI_BUS_SUP];
            nf.input_current_optimizer_enable = i_reg_wdata[coc_pkg::HI_ICO];
        end
        if (wr_lo) begin
            nf.conservative_assist_enable      = i_reg_wdata[coc_pkg::LO_CONS];
            nf.shared_pin_function_select      = i_reg_wdata[coc_pkg::LO_PIN_SEL];
            nf.inductor_avg_current_clamp      =
                i_reg_wdata[coc_pkg::LO_CLAMP_HI:coc_pkg::LO_CLAMP_LO];
            nf.bus_supply_low_range            = i_reg_wdata[coc_pkg::LO_LOW_RANGE];
            nf.battery_switch_off_in_highz     = i_reg_wdata[coc_pkg::LO_BATSW_OFF];
            nf.power_monitor_bus_supply_select = i_reg_wdata[coc_pkg::LO_PMON_SEL];
        end
        // Re-measure: a fresh write of 1 beats the done clear in the same cycle
        if (i_remeasure_done) begin
            nf.input_vreg_remeasure = 1'b0;
        end
        if (wr_hi && i_reg_wdata[coc_pkg::HI_REMEASURE]) begin
            nf.input_vreg_remeasure = 1'b1;
        end
        // Soft reset overrides the whole byte pair, including a pending measurement
        if (soft_rst) begin
            nf = def_f;
        end
        next_st.f = nf;

        // Read path, one cycle latency; reserved bits and the soft reset bit read zero
        next_st.rvalid = i_reg_rd;
        next_st.rdata  = coc_pkg::UNMAPPED_DATA;
        if (i_reg_rd && (i_reg_addr == coc_pkg::ADDR_HIGH)) begin
            next_st.rdata = {st.f.highz_mode_enable, 1'b0,
                             st.f.input_vreg_remeasure,
                             st.f.bus_supply_mode_enable,
                             st.f.input_current_optimizer_enable, 3'h0};
        end else if (i_reg_rd && (i_reg_addr == coc_pkg::ADDR_LOW)) begin
            next_st.rdata = {1'b0,
                             st.f.conservative_assist_enable,
                             st.f.shared_pin_function_select,
                             st.f.inductor_avg_current_clamp,
                             st.f.bus_supply_low_range,
                             st.f.battery_switch_off_in_highz,
                             st.f.power_monitor_bus_supply_select};
        end

        // Derived controls follow the new field values in the same cycle
        next_st.highz             = nf.highz_mode_enable;
        next_st.regulator_on      = i_vbus_above_uvlo;
        next_st.sys_from_battery  = nf.highz_mode_enable;
        next_st.battery_switch_on = !(nf.highz_mode_enable &&
                                      nf.battery_switch_off_in_highz);
        // Converter idles in high-impedance mode and during a measurement
        next_st.converter_enable  = !nf.highz_mode_enable &&
                                    !nf.input_vreg_remeasure;
        next_st.regs_reset        = soft_rst;
        next_st.remeasure_start   = nf.input_vreg_remeasure &&
                                    !st.f.input_vreg_remeasure;
        next_st.bus_supply_active = nf.bus_supply_mode_enable &&
                                    nf.shared_pin_function_select &&
                                    i_shared_pin;
        next_st.assist_pin_enable = !nf.shared_pin_function_select &&
                                    i_shared_pin;
        next_st.optimizer_run     = nf.input_current_optimizer_enable;
        next_st.conservative_assist = nf.conservative_assist_enable;
        next_st.low_range         = nf.bus_supply_low_range;
        next_st.pmon_subtract_bus = next_st.bus_supply_active &&
                                    !nf.power_monitor_bus_supply_select;
        next_st.clamp_amps        = clamp_amps;
        next_st.clamp_disabled    = clamp_off;
    end

    // State register; reset loads constants only
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st                     <= '0;
            st.f                   <= def_f;
            st.regulator_on        <= 1'b0;
            st.battery_switch_on   <= 1'b1;
            st.converter_enable    <= 1'b1;
            st.clamp_amps          <= coc_pkg::AMPS_15;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign o_reg_rdata           = st.rdata;
    assign o_reg_rvalid          = st.rvalid;
    assign o_highz               = st.highz;
    assign o_regulator_on        = st.regulator_on;
    assign o_sys_from_battery    = st.sys_from_battery;
    assign o_battery_switch_on   = st.battery_switch_on;
    assign o_converter_enable    = st.converter_enable;
    assign o_regs_reset          = st.regs_reset;
    assign o_remeasure_start     = st.remeasure_start;
    assign o_bus_supply_active   = st.bus_supply_active;
    assign o_assist_pin_enable   = st.assist_pin_enable;
    assign o_optimizer_run       = st.optimizer_run;
    assign o_conservative_assist = st.conservative_assist;
    assign o_low_range           = st.low_range;
    assign o_pmon_subtract_bus   = st.pmon_subtract_bus;
    assign o_clamp_amps          = st.clamp_amps;
    assign o_clamp_disabled      = st.clamp_disabled;
    // Constant handed to the system-voltage register on soft reset
    assign o_min_sys_reload_mv   = coc_pkg::MIN_SYS_1CELL_MV;

    // First edge after any reset release shows the power-on register and an idle read port
    reset_value_a: assert property (@(posedge i_ref_clk)
        $fell(i_rst) |-> st.f == def_f && !o_reg_rvalid && o_battery_switch_on
        && o_converter_enable && o_clamp_amps == coc_pkg::AMPS_15 && !o_clamp_disabled)
        else $error("register does not hold its reset value after reset");

    // Mode bit reaches its output one cycle after the byte write
    highz_follows_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_hi && !soft_rst |=> o_highz == $past(i_reg_wdata[coc_pkg::HI_HIGHZ]))
        else $error("high-impedance output does not follow the written bit");

    // No switching while the device idles in high-impedance mode
    highz_converter_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_highz |-> !o_converter_enable && o_sys_from_battery)
        else $error("converter active while in high-impedance mode");

    // One pulse per soft reset; a back-to-back second request may legally extend it
    soft_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        soft_rst |=> o_regs_reset && !o_highz && !o_optimizer_run && !o_low_range
        ##1 (!o_regs_reset || $past(soft_rst)))
        else $error("soft reset did not restore defaults for one pulse");

    // Converter stays off for as long as a measurement is pending
    remeasure_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        st.f.input_vreg_remeasure || o_remeasure_start |-> !o_converter_enable)
        else $error("converter running during threshold measurement");

    // Restart follows done directly; a write in that cycle may legally re-arm it
    remeasure_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_remeasure_done && !wr_hi && !o_highz |=> o_converter_enable)
        else $error("converter did not restart after measurement");

    // Bus supply needs the enable bit, the pin function and the pin together
    bus_supply_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_bus_supply_active |-> $past(i_shared_pin) && o_assist_pin_enable == 1'b0
        && st.f.bus_supply_mode_enable && st.f.shared_pin_function_select)
        else $error("bus supply active without the pin");

    // Subtraction only makes sense while the bus is being supplied
    pmon_select_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_pmon_subtract_bus |-> o_bus_supply_active)
        else $error("monitor subtracts bus power outside bus supply mode");

    // Battery switch may only open in high-impedance mode
    switch_highz_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !o_battery_switch_on |-> o_highz)
        else $error("battery switch off outside high-impedance mode");

    // A disabled clamp reports no limit
    clamp_code_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_clamp_disabled |-> o_clamp_amps == coc_pkg::AMPS_NONE)
        else $error("disabled clamp still reports a limit");

    // Upper-byte reserved bits and the soft reset bit never read back as one
    reserved_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_reg_rd && i_reg_addr == coc_pkg::ADDR_HIGH |=> o_reg_rdata[2:0] == 3'h0
        && o_reg_rdata[coc_pkg::HI_SOFT_RST] == 1'b0)
        else $error("reserved or self-clearing bits read non-zero");

    // Regulator tracks the lockout input one cycle late, whatever the mode
    regulator_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !$past(i_rst) |-> o_regulator_on == $past(i_vbus_above_uvlo))
        else $error("regulator does not follow the input lockout");

    // Optimizer runs exactly as the last upper-byte write asked
    optimizer_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_hi && !soft_rst |=> o_optimizer_run == $past(i_reg_wdata[coc_pkg::HI_ICO]))
        else $error("optimizer output does not follow its enable bit");

    // Conservative assist variant follows its lower-byte bit
    conservative_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_lo |=> o_conservative_assist == $past(i_reg_wdata[coc_pkg::LO_CONS]))
        else $error("conservative assist does not follow its bit");

    // Output range select follows its lower-byte bit
    range_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_lo |=> o_low_range == $past(i_reg_wdata[coc_pkg::LO_LOW_RANGE]))
        else $error("bus supply range does not follow its bit");

    // Pin drives assist mode only when the pin function says so
    assist_pin_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_assist_pin_enable |-> $past(i_shared_pin) && !st.f.shared_pin_function_select)
        else $error("assist request without the pin or with the wrong pin function");

    // A fresh re-measure write starts a measurement and stops the converter
    remeasure_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_hi && i_reg_wdata[coc_pkg::HI_REMEASURE] && !soft_rst && !st.f.input_vreg_remeasure
        |=> o_remeasure_start && !o_converter_enable)
        else $error("re-measure write did not start a measurement");

    // Middle clamp code maps onto its own limit
    clamp_ten_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_lo && i_reg_wdata[coc_pkg::LO_CLAMP_HI:coc_pkg::LO_CLAMP_LO] == coc_pkg::CLAMP_10A
        |=> o_clamp_amps == coc_pkg::AMPS_10 && !o_clamp_disabled)
        else $error("clamp code for ten amperes decoded wrongly");

    // Foreign addresses answer with a plain zero byte so the engine never stalls
    unmapped_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_reg_rd && i_reg_addr != coc_pkg::ADDR_HIGH && i_reg_addr != coc_pkg::ADDR_LOW
        |=> o_reg_rvalid && o_reg_rdata == coc_pkg::UNMAPPED_DATA)
        else $error("unmapped read did not return zero");

    // Default monitor setting subtracts the supplied bus power
    pmon_subtract_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_bus_supply_active && !st.f.power_monitor_bus_supply_select |-> o_pmon_subtract_bus)
        else $error("monitor does not subtract bus power in bus supply mode");

    // Switch-off bit opens the battery switch during high-impedance mode
    switch_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_highz && st.f.battery_switch_off_in_highz |-> !o_battery_switch_on)
        else $error("battery switch closed although asked open in high-impedance mode");

endmodule : coc_option_ctrl
`default_nettype wire

// ---- dv/coc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module coc_host_model (
    input  wire logic       i_ref_clk,  // Bus clock
    input  wire logic [7:0] i_rdata,    // Read byte from the register
    input  wire logic       i_rvalid,   // Read byte valid
    output logic      [7:0] o_addr,     // Byte address
    output logic            o_wr,       // Write strobe
    output logic            o_rd,       // Read strobe
    output logic      [7:0] o_wdata     // Write byte
);
    // Idle bus from time zero so no strobe is seen during reset
    initial begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 8'h00;
    end

    // One-cycle strobe; data is inverted afterwards so a stale byte never looks valid
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_ref_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
    endtask : wr_byte

    // The answer stands for one cycle only, so it is taken just after the strobe edge
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_ref_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_ref_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask : rd_byte
endmodule : coc_host_model
`default_nettype wire

// ---- dv/test_charger_option_control_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_charger_option_control_reg;
    logic        clk = 1'b0;
    logic        rst, vbus, pin, done, wr, rd, rvalid, v;
    logic [7:0]  addr, wdata, rdata, hi, lo, w, rb;
    logic        hz, sysb, bsw, conv, rreset, rstart, bsa, asp, opt, cons, lowr, pmon, cdis, reg_on;
    logic [4:0]  amps;
    logic [11:0] minsys;
    logic [15:0] obs;
    int          bad_count, total_checks, i;
    integer      seed;

    always #5 clk = ~clk;

    // Observed control outputs packed in the same order as the expectation
    assign obs = {hz, sysb, bsw, conv, bsa, asp, opt, cons, lowr, pmon, cdis, amps};

    coc_host_model host_u (.i_ref_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    coc_option_ctrl dut_u (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .i_vbus_above_uvlo(vbus), .i_shared_pin(pin),
        .i_remeasure_done(done), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_highz(hz),
        .o_regulator_on(reg_on), .o_sys_from_battery(sysb), .o_battery_switch_on(bsw),
        .o_converter_enable(conv), .o_regs_reset(rreset), .o_remeasure_start(rstart),
        .o_bus_supply_active(bsa), .o_assist_pin_enable(asp), .o_optimizer_run(opt),
        .o_conservative_assist(cons), .o_low_range(lowr), .o_pmon_subtract_bus(pmon),
        .o_clamp_amps(amps), .o_clamp_disabled(cdis), .o_min_sys_reload_mv(minsys));

    // Expected control outputs from the stored bytes and the shared pin
    function automatic logic [15:0] exp_out(input logic [7:0] h, input logic [7:0] l,
                                            input logic p);
        logic       z, s;
        logic [4:0] a;
        z = h[7];
        s = h[4] & l[5] & p;
        case (l[4:3])
            2'h0: a = 5'h06;
            2'h1: a = 5'h0A;
            2'h2: a = 5'h0F;
            default: a = 5'h00;
        endcase
        exp_out = {z, z, ~(z & l[1]), ~z & ~h[5], s, ~l[5] & p, h[3], l[6], l[2], s & ~l[0],
                   &l[4:3], a};
    endfunction : exp_out

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        host_u.rd_byte(a, rb, v);
        check("rvalid", 16'(v), 16'h0001);
        check("rdata", 16'(rb), 16'(e));
    endtask : rd_check

    task automatic final_report;
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    // Main sequence: defaults, unmapped access, random fields, re-measure, soft reset
    initial begin
        seed = 32'h403CA422;
        bad_count = 0;
        total_checks = 0;
        rst = 1'b1;
        vbus = 1'b0;
        pin = 1'b0;
        done = 1'b0;
        hi = 8'h00;
        lo = 8'h30;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("reset_outputs", obs, exp_out(hi, lo, pin));
        rd_check(coc_pkg::ADDR_LOW, 8'h30);
        rd_check(coc_pkg::ADDR_HIGH, 8'h00);
        host_u.wr_byte(8'h36, 8'hFF);
        rd_check(8'h36, coc_pkg::UNMAPPED_DATA);
        rd_check(coc_pkg::ADDR_LOW, 8'h30);
        for (i = 0; i < 40; i++) begin
            lo = 8'($random(seed));
            w = 8'($random(seed)) & 8'h9F;
            // First passes walk every clamp code with the pin given to bus supply
            if (i < 4) begin
                lo = {3'h1, i[1:0], 3'h0};
                w = 8'h9F;
            end
            @(posedge clk);
            pin <= 1'($random(seed));
            vbus <= 1'($random(seed));
            host_u.wr_byte(coc_pkg::ADDR_LOW, lo);
            host_u.wr_byte(coc_pkg::ADDR_HIGH, w);
            lo[7] = 1'b0;
            hi = w & 8'h98;
            @(posedge clk);
            #1;
            check("outputs", obs, exp_out(hi, lo, pin));
            check("regulator", 16'(reg_on), 16'(vbus));
            rd_check(coc_pkg::ADDR_LOW, lo);
            rd_check(coc_pkg::ADDR_HIGH, hi);
        end
        host_u.wr_byte(coc_pkg::ADDR_HIGH, 8'h20);
        #1;
        check("remeasure_start", 16'(rstart), 16'h0001);
        check("converter_stop", 16'(conv), 16'h0000);
        @(posedge clk);
        #1;
        check("remeasure_pulse", 16'(rstart), 16'h0000);
        rd_check(coc_pkg::ADDR_HIGH, 8'h20);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
        #1;
        check("converter_restart", 16'(conv), 16'h0001);
        rd_check(coc_pkg::ADDR_HIGH, 8'h00);
        host_u.wr_byte(coc_pkg::ADDR_LOW, 8'h5F);
        host_u.wr_byte(coc_pkg::ADDR_HIGH, 8'h98);
        // Soft reset is sent only with the battery taken as present and healthy
        host_u.wr_byte(coc_pkg::ADDR_HIGH, 8'h40);
        #1;
        check("regs_reset", 16'(rreset), 16'h0001);
        @(posedge clk);
        #1;
        check("regs_reset_pulse", 16'(rreset), 16'h0000);
        check("min_sys", 16'(minsys), 16'h0E00);
        check("soft_outputs", obs, exp_out(8'h00, 8'h30, pin));
        rd_check(coc_pkg::ADDR_LOW, 8'h30);
        rd_check(coc_pkg::ADDR_HIGH, 8'h00);
        // Mid-run reset over written fields must bring back the power-on value
        host_u.wr_byte(coc_pkg::ADDR_HIGH, 8'h98);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("rerun_outputs", obs, exp_out(8'h00, 8'h30, pin));
        rd_check(coc_pkg::ADDR_HIGH, 8'h00);
        rd_check(coc_pkg::ADDR_LOW, 8'h30);
        final_report();
    end
endmodule : test_charger_option_control_reg
`default_nettype wire
